// >>> hw/bfcs_bank.sv
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "bfcs_consts.svh"
module bfcs_bank #(
  parameter int BEATS = `BFCS_BEATS
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Register bus
  input wire logic [4:0] i_av_address,
  input wire logic i_av_read,
  input wire logic i_av_write,
  input wire bfcs_pkg::bfcs_word_t i_av_writedata,
  input wire logic [3:0] i_av_byteenable,
  output bfcs_pkg::bfcs_word_t o_av_readdata,
  output logic o_av_waitrequest,
  // Access request from the core
  input wire logic i_acc_req,
  input wire bfcs_pkg::bfcs_word_t i_acc_addr,
  input wire bfcs_pkg::bfcs_atype_t i_acc_type,
  input wire logic i_acc_write,
  input wire logic i_acc_burst,
  input wire bfcs_pkg::bfcs_word_t i_acc_wdata,
  input wire logic i_prev_other_bank,
  output logic o_acc_ack,
  output logic o_acc_miss,
  output logic o_acc_valid,
  output bfcs_pkg::bfcs_word_t o_acc_rdata,
  // Flash pins
  output bfcs_pkg::bfcs_word_t o_addr,
  output logic o_ts_n,
  output logic o_cs_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_burst_in_progress_n,
  input wire bfcs_pkg::bfcs_word_t i_data,
  output bfcs_pkg::bfcs_word_t o_data,
  output logic o_data_oe_n
);
  import bfcs_pkg::*;

  localparam int BW = (BEATS > 1) ? $clog2(BEATS) : 1;

  function automatic logic bfcs_hit(input bfcs_word_t a, input bfcs_atype_t t,
                                    input bfcs_word_t b, input bfcs_word_t o);
    logic [16:0] m;
    m = o[`BFCS_MASK_HI:`BFCS_MASK_LO];
    bfcs_hit = b[`BFCS_VALID]
      && (((a[`BFCS_MASK_HI:`BFCS_MASK_LO] ^ b[`BFCS_MASK_HI:`BFCS_MASK_LO]) & m) == 17'h0)
      && (((t ^ b[`BFCS_AT_HI:`BFCS_AT_LO]) & o[`BFCS_AT_HI:`BFCS_AT_LO]) == 3'h0);
  endfunction : bfcs_hit

  function automatic bfcs_word_t bfcs_merge(input bfcs_word_t old, input bfcs_word_t wd,
                                           input logic [3:0] be);
    for (int k = 0; k < 4; k++) begin
      bfcs_merge[8*k +: 8] = be[k] ? wd[8*k +: 8] : old[8*k +: 8];
    end
  endfunction : bfcs_merge

  bfcs_word_t base_q, opt_q, op_addr_q, op_addr_d, op_wdata_q, op_wdata_d, buf_rd;
  bfcs_state_e state_q, state_d;
  logic [3:0] wcnt_q, wcnt_d, access_wait_count;
  logic [2:0] beat_wait_count;
  logic [BW-1:0] beat_q, beat_d;
  logic op_wr_q, op_wr_d, op_burst_q, op_burst_d, op_cmd_q, op_cmd_d;
  logic sync_q, cmd_pend_q, ph_q;
  logic hit_now, start, accept, capture, done, slow_neg, need_setup, bus_d, ts_d, miss_d;
  logic av_req, av_take, ctrl_wr;

  assign access_wait_count = opt_q[`BFCS_SCY_HI:`BFCS_SCY_LO];
  assign beat_wait_count = opt_q[`BFCS_BEAT_WAIT_COUNT_HI:`BFCS_BEAT_WAIT_COUNT_LO];
  assign slow_neg = opt_q[`BFCS_SELECT_NEGATION_TIMING] | opt_q[`BFCS_RELAXED_TIMING];
  assign need_setup = (opt_q[`BFCS_ACS_HI:`BFCS_ACS_LO] != 2'h0) | opt_q[`BFCS_RELAXED_TIMING];
  assign hit_now = bfcs_hit(i_acc_addr, i_acc_type, base_q, opt_q);
  // A held request is not taken again while its own answer is still showing.
  assign start = !o_acc_ack && !o_acc_miss && (cmd_pend_q || (i_acc_req && hit_now));
  assign miss_d = (state_q == st_idle) && i_acc_req && !hit_now && !cmd_pend_q
    && !o_acc_ack && !o_acc_miss;

  // Register bus: answer two cycles after the request rises.
  assign av_req = i_av_read | i_av_write;
  assign av_take = av_req && !o_av_waitrequest;
  assign ctrl_wr = av_take && i_av_write && (i_av_address == `BFCS_OFF_CTRL)
    && i_av_byteenable[0] && i_av_writedata[`BFCS_CTRL_TOGGLE];

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_av_waitrequest <= 1'b1;
      ph_q <= 1'b0;
      o_av_readdata <= '0;
    end else if (i_ce) begin
      if (!o_av_waitrequest) begin
        o_av_waitrequest <= 1'b1;
        ph_q <= 1'b0;
      end else if (av_req && ph_q) begin
        o_av_waitrequest <= 1'b0;
        ph_q <= 1'b0;
        case (i_av_address)
          `BFCS_OFF_BASE: o_av_readdata <= base_q;
          `BFCS_OFF_OPT: o_av_readdata <= opt_q;
          `BFCS_OFF_STAT: o_av_readdata <= {29'h0, cmd_pend_q, sync_q, state_q != st_idle};
          default: o_av_readdata <= (i_av_address[4]) ? buf_rd : 32'h0;
        endcase
      end else if (av_req) begin
        ph_q <= 1'b1;
      end
    end
  end

  // Configuration registers; the option reset gives the long boot access.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      base_q <= `BFCS_BASE_RST;
      opt_q <= `BFCS_OPT_RST;
    end else if (i_ce && av_take && i_av_write) begin
      if (i_av_address == `BFCS_OFF_BASE) begin
        base_q <= bfcs_merge(base_q, i_av_writedata, i_av_byteenable);
      end
      if (i_av_address == `BFCS_OFF_OPT) begin
        opt_q <= bfcs_merge(opt_q, i_av_writedata, i_av_byteenable);
      end
    end
  end

  // Flash mode tracking; a new software request wins over the issue clearing it.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cmd_pend_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (i_ce) begin
      cmd_pend_q <= ctrl_wr | (cmd_pend_q & ~(accept & op_cmd_d));
      if (done && op_cmd_q) begin
        sync_q <= ~sync_q;
      end
    end
  end

  // Access sequencer.
  always_comb begin
    state_d = state_q;
    wcnt_d = wcnt_q;
    beat_d = beat_q;
    accept = 1'b0;
    capture = 1'b0;
    done = 1'b0;
    case (state_q)
      st_idle: begin
        if (start) begin
          accept = 1'b1;
          wcnt_d = 4'h0;
          beat_d = '0;
          if (opt_q[`BFCS_EXTRA_TURNAROUND_CYCLE] && i_prev_other_bank) begin
            state_d = st_turn;
          end else begin
            state_d = need_setup ? st_setup : st_lead;
          end
        end
      end
      st_turn: state_d = need_setup ? st_setup : st_lead;
      st_setup: state_d = st_lead;
      st_lead: begin
        if (wcnt_q == access_wait_count) begin
          capture = !op_wr_q;
          wcnt_d = 4'h0;
          beat_d = BW'(1);
          if (op_burst_q) begin
            state_d = st_beat;
          end else if (slow_neg) begin
            state_d = st_neg;
          end else begin
            state_d = st_idle;
            done = 1'b1;
          end
        end else begin
          wcnt_d = wcnt_q + 4'h1;
        end
      end
      st_beat: begin
        if (wcnt_q == {1'b0, beat_wait_count}) begin
          capture = 1'b1;
          wcnt_d = 4'h0;
          beat_d = beat_q + BW'(1);
          if (beat_q == BW'(BEATS - 1)) begin
            if (slow_neg) begin
              state_d = st_neg;
            end else begin
              state_d = st_idle;
              done = 1'b1;
            end
          end
        end else begin
          wcnt_d = wcnt_q + 4'h1;
        end
      end
      st_neg: begin
        state_d = st_idle;
        done = 1'b1;
      end
      default: state_d = st_idle;
    endcase
  end

  always_comb begin
    op_cmd_d = op_cmd_q;
    op_wr_d = op_wr_q;
    op_burst_d = op_burst_q;
    op_addr_d = op_addr_q;
    op_wdata_d = op_wdata_q;
    if (accept) begin
      op_cmd_d = cmd_pend_q;
      op_wr_d = cmd_pend_q | i_acc_write;
      // Bursts only once the flash is in synchronous mode and not inhibited.
      op_burst_d = !cmd_pend_q && !i_acc_write && i_acc_burst && sync_q
        && !base_q[`BFCS_BI];
      op_addr_d = cmd_pend_q ? {base_q[`BFCS_MASK_HI:`BFCS_MASK_LO], 15'h0} : i_acc_addr;
      op_wdata_d = cmd_pend_q ? {24'h0, `BFCS_TOGGLE_CMD} : i_acc_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= st_idle;
      wcnt_q <= 4'h0;
      beat_q <= '0;
      op_cmd_q <= 1'b0;
      op_wr_q <= 1'b0;
      op_burst_q <= 1'b0;
      op_addr_q <= '0;
      op_wdata_q <= '0;
    end else if (i_ce) begin
      state_q <= state_d;
      wcnt_q <= wcnt_d;
      beat_q <= beat_d;
      op_cmd_q <= op_cmd_d;
      op_wr_q <= op_wr_d;
      op_burst_q <= op_burst_d;
      op_addr_q <= op_addr_d;
      op_wdata_q <= op_wdata_d;
    end
  end

  // Pins are registered from the next state so they move with the state.
  assign bus_d = (state_d == st_lead) || (state_d == st_beat);
  assign ts_d = (state_d == st_setup)
    || ((state_d == st_lead) && (state_q != st_lead) && (state_q != st_setup));

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_addr <= '0;
      o_ts_n <= 1'b1;
      o_cs_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_burst_in_progress_n <= 1'b1;
      o_data <= '0;
      o_data_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_addr <= op_addr_d;
      o_ts_n <= !ts_d;
      o_cs_n <= !bus_d;
      o_oe_n <= !(bus_d && !op_wr_d);
      // Write enable waits one cycle so the address is latched first.
      o_we_n <= !((state_d == st_lead) && (state_q == st_lead) && op_wr_q);
      o_burst_in_progress_n <= !(bus_d && op_burst_d);
      o_data <= op_wdata_d;
      o_data_oe_n <= !(bus_d && op_wr_d);
    end
  end

  // Answers to the core.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_acc_ack <= 1'b0;
      o_acc_miss <= 1'b0;
      o_acc_valid <= 1'b0;
      o_acc_rdata <= '0;
    end else if (i_ce) begin
      o_acc_ack <= done && !op_cmd_q;
      o_acc_miss <= miss_d;
      o_acc_valid <= capture;
      if (capture) begin
        o_acc_rdata <= i_data;
      end
    end
  end

  // Captured beats stay readable over the register bus for debug; a single read overwrites entry 0.
  bfcs_beat_buf #(.WIDTH(32), .DEPTH(BEATS), .AW(BW)) u_buf (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_wr_en(capture),
    .i_wr_idx(beat_q),
    .i_wr_data(i_data),
    .i_rd_idx(i_av_address[BW+1:2]),
    .o_rd_data(buf_rd)
  );

  // Checking helpers.
  logic [4:0] lat_h, gap_h;
  logic [3:0] vcnt_h;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      lat_h <= 5'h0;
      gap_h <= 5'h0;
      vcnt_h <= 4'h0;
    end else if (i_ce) begin
      lat_h <= !o_ts_n ? 5'h0 : ((lat_h == 5'h1f) ? lat_h : lat_h + 5'h1);
      gap_h <= o_acc_valid ? 5'h0 : ((gap_h == 5'h1f) ? gap_h : gap_h + 5'h1);
      vcnt_h <= !o_ts_n ? 4'h0 : (o_acc_valid ? vcnt_h + 4'h1 : vcnt_h);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset || !i_ce);

  a_select_on_match: assert property (
    miss_d |=> o_acc_miss && o_cs_n && (state_q == st_idle))
    else $error("chip select taken on a masked mismatch");
  a_cs_with_addr: assert property (
    $fell(o_ts_n) && !need_setup |-> !o_cs_n)
    else $error("select not asserted together with address");
  a_ts_single: assert property (
    $fell(o_ts_n) |=> o_ts_n)
    else $error("transfer start longer than one cycle");
  a_first_capture: assert property (
    o_acc_valid && (vcnt_h == 4'h0) && !need_setup |-> lat_h == {1'b0, access_wait_count})
    else $error("first data not captured after programmed waits");
  a_beat_spacing: assert property (
    o_acc_valid && (vcnt_h != 4'h0) |-> gap_h == {2'b00, beat_wait_count})
    else $error("beat spacing differs from programmed waits");
  // Without slow negation the last beat shows in the acknowledge cycle, before the counter has taken it.
  a_burst_beats: assert property (
    o_acc_ack && op_burst_q |-> ((vcnt_h + {3'h0, o_acc_valid}) == 4'(BEATS))
      && o_cs_n && o_burst_in_progress_n)
    else $error("burst ended with wrong beat count or select low");
  a_toggle_cmd: assert property (
    $rose(o_cs_n) && op_cmd_q |-> (sync_q != $past(sync_q)) && (o_data[7:0] == 8'h60))
    else $error("mode toggle command not issued correctly");
  a_turn_idle: assert property (
    state_q == st_turn |-> o_cs_n && o_ts_n && o_data_oe_n)
    else $error("bus not idle during turnaround cycle");
  a_slow_negation: assert property (
    o_acc_ack && slow_neg |-> $past(state_q) == st_neg)
    else $error("negation cycle missing");
  a_burst_in_progress_early: assert property (
    $fell(o_ts_n) && op_burst_q |-> !o_burst_in_progress_n ##1 !o_cs_n)
    else $error("burst strobe not asserted with start");

  c_async_read: cover property (o_acc_ack && !op_wr_q && !op_burst_q);
  c_sync_burst: cover property (o_acc_ack && op_burst_q);
  c_toggle: cover property ($rose(o_cs_n) && op_cmd_q);
  c_miss: cover property (o_acc_miss);
endmodule : bfcs_bank

// >>> hw/bfcs_beat_buf.sv
`timescale 1ns/10ps
module bfcs_beat_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Write side
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_idx,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read side
  input wire logic [AW-1:0] i_rd_idx,
  output logic [WIDTH-1:0] o_rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_ce && i_wr_en) begin
      mem[i_wr_idx] <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= '0;
    end else if (i_ce) begin
      o_rd_data <= mem[i_rd_idx];
    end
  end
endmodule : bfcs_beat_buf

// >>> hw/bfcs_consts.svh
`ifndef BFCS_CONSTS_SVH
`define BFCS_CONSTS_SVH
// Byte offsets on the register bus.
`define BFCS_OFF_BASE 5'h00
`define BFCS_OFF_OPT 5'h04
`define BFCS_OFF_CTRL 5'h08
`define BFCS_OFF_STAT 5'h0c
`define BFCS_OFF_BUF 5'h10
// Option word fields, held LSB-first; MSB-first bit n sits at word bit 31-n.
`define BFCS_MASK_HI 31
`define BFCS_MASK_LO 15
`define BFCS_AT_HI 14
`define BFCS_AT_LO 12
`define BFCS_SELECT_NEGATION_TIMING 11
`define BFCS_ACS_HI 10
`define BFCS_ACS_LO 9
`define BFCS_EXTRA_TURNAROUND_CYCLE 8
`define BFCS_SCY_HI 7
`define BFCS_SCY_LO 4
`define BFCS_BEAT_WAIT_COUNT_HI 3
`define BFCS_BEAT_WAIT_COUNT_LO 1
`define BFCS_RELAXED_TIMING 0
// Base word fields.
`define BFCS_BI 1
`define BFCS_VALID 0
// Control and status bits.
`define BFCS_CTRL_TOGGLE 0
`define BFCS_ST_BUSY 0
`define BFCS_ST_SYNC 1
`define BFCS_ST_PEND 2
// Reset values: boot with every address matched and the longest first access.
`define BFCS_BOOT_WAITS 4'hf
`define BFCS_OPT_RST {24'h000000, `BFCS_BOOT_WAITS, 4'h0}
`define BFCS_BASE_RST 32'h00000003
// Flash mode toggle command and beats per burst.
`define BFCS_TOGGLE_CMD 8'h60
`define BFCS_BEATS 4
`endif

// >>> hw/bfcs_pkg.sv
package bfcs_pkg;
  typedef enum logic [2:0] {st_idle, st_turn, st_setup, st_lead, st_beat, st_neg} bfcs_state_e;
  typedef logic [31:0] bfcs_word_t;
  typedef logic [2:0] bfcs_atype_t;
endpackage : bfcs_pkg

// >>> verif/bfcs_flash_model.sv
`timescale 1ns/10ps
module bfcs_flash_model #(
  parameter int XLAT = 2
) (
  // Bus from the bank
  input wire logic i_mclk,
  input wire bfcs_pkg::bfcs_word_t i_addr,
  input wire logic i_ts_n,
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_data_oe_n,
  input wire bfcs_pkg::bfcs_word_t i_wdata,
  // Read data back
  output bfcs_pkg::bfcs_word_t o_q
);
  import bfcs_pkg::*;
  // Powers up asynchronous so that slow boot reads succeed.
  logic sync_q = 1'b0;
  logic pend_q = 1'b0;
  bfcs_word_t base_q = '0;
  bfcs_word_t last_q = '0;
  bfcs_word_t a;
  int cnt_q = 0;
  int idx;
  logic sel;
  always @(posedge i_mclk) begin
    if (!i_ts_n) begin
      base_q <= i_addr;
      cnt_q <= 0;
    end else if (!i_cs_n) begin
      cnt_q <= cnt_q + 1;
    end
    if (!i_cs_n && !i_we_n && !i_data_oe_n && i_wdata[7:0] == 8'h60) pend_q <= 1'b1;
    // The mode only flips once the command cycle has been closed by chip select.
    if (i_cs_n && pend_q) begin
      sync_q <= !sync_q;
      pend_q <= 1'b0;
    end
    if (sel) last_q <= o_q;
  end
  always_comb begin
    idx = cnt_q - XLAT + 1;
    if (idx < 0) idx = 0;
    a = sync_q ? base_q + 32'(4 * idx) : i_addr;
    sel = !i_cs_n && !i_oe_n;
  end
  // A released bus shows the inverse of its last word, never a stale copy.
  assign o_q = sel ? {~a[15:0], a[15:0]} : ~last_q;
endmodule : bfcs_flash_model

// >>> verif/burst_flash_chip_select_bank_tb.sv
`timescale 1ns/10ps
module burst_flash_chip_select_bank_tb;
  import bfcs_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [4:0] av_addr = 5'h00;
  bfcs_word_t av_wdata = '0;
  bfcs_word_t av_rdata, rdata, addr, q, dout, r;
  logic av_wait, ack, miss, valid, ts_n, cs_n, oe_n, we_n, burst_in_progress_n, doe_n;
  logic req = 1'b0;
  bfcs_word_t acc_addr = '0;
  bfcs_atype_t acc_type = 3'h0;
  logic acc_burst = 1'b0;
  logic prev_other = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int v_first, v_last, n_ack, n_ts, n_cs, n_miss, n_val, n_bd;

  bfcs_bank u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1),
    .i_av_address(av_addr), .i_av_read(av_rd), .i_av_write(av_wr), .i_av_writedata(av_wdata),
    .i_av_byteenable(4'hf), .o_av_readdata(av_rdata), .o_av_waitrequest(av_wait),
    .i_acc_req(req), .i_acc_addr(acc_addr), .i_acc_type(acc_type), .i_acc_write(1'b0),
    .i_acc_burst(acc_burst), .i_acc_wdata(32'h00000000), .i_prev_other_bank(prev_other),
    .o_acc_ack(ack), .o_acc_miss(miss), .o_acc_valid(valid), .o_acc_rdata(rdata),
    .o_addr(addr), .o_ts_n(ts_n), .o_cs_n(cs_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_burst_in_progress_n(burst_in_progress_n), .i_data(q), .o_data(dout), .o_data_oe_n(doe_n));

  bfcs_flash_model #(.XLAT(2)) u_flash (.i_mclk(i_mclk), .i_addr(addr), .i_ts_n(ts_n),
    .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_data_oe_n(doe_n), .i_wdata(dout), .o_q(q));

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // A hung handshake would otherwise stall the run forever.
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic av(input logic wr, input logic [4:0] a, input bfcs_word_t d);
    @(posedge i_mclk);
    av_rd <= !wr;
    av_wr <= wr;
    av_addr <= a;
    av_wdata <= d;
    do @(posedge i_mclk); while (av_wait !== 1'b0);
    r = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : av

  // Edge counts are taken from the edge that launches the request.
  task automatic acc(input bfcs_word_t a, input bfcs_atype_t t, input logic b);
    bfcs_word_t e;
    v_first = 0;
    v_last = 0;
    n_bd = 0;
    n_ack = 0;
    n_ts = 0;
    n_cs = 0;
    n_miss = 0;
    n_val = 0;
    @(posedge i_mclk);
    req <= 1'b1;
    acc_addr <= a;
    acc_type <= t;
    acc_burst <= b;
    for (int n = 1; n < 60 && n_ack == 0 && n_miss == 0; n++) begin
      @(posedge i_mclk);
      if (ts_n === 1'b0) n_ts++;
      if (cs_n === 1'b0) n_cs++;
      if (burst_in_progress_n === 1'b0) n_bd++;
      if (miss === 1'b1) n_miss = n;
      if (ack === 1'b1) n_ack = n;
      if (valid === 1'b1) begin
        e = a + 32'(4 * n_val);
        chk("read data", {~e[15:0], e[15:0]}, rdata);
        if (n_val == 0) v_first = n;
        v_last = n;
        n_val++;
      end
    end
    req <= 1'b0;
  endtask : acc

  task automatic t_reset_regs();
    av(1'b0, 5'h00, '0);
    chk("base reset", 32'h00000003, r);
    av(1'b0, 5'h04, '0);
    chk("option reset", 32'h000000f0, r);
    av(1'b1, 5'h0c, 32'h00000007);
    av(1'b0, 5'h0c, '0);
    chk("status read only", 32'h00000000, r);
  endtask : t_reset_regs

  task automatic t_boot_read();
    acc(32'h00000100, 3'h0, 1'b0);
    chk("boot valid edge", 18, v_first);
    chk("boot ack edge", 18, n_ack);
    chk("boot select cycles", 16, n_cs);
    chk("boot start cycles", 1, n_ts);
    chk("boot burst strobe cycles", 0, n_bd);
  endtask : t_boot_read

  task automatic t_decode();
    bfcs_word_t ad[5] = '{32'h00180040, 32'h00200040, 32'h10100040, 32'h00100040, 32'h00100040};
    bfcs_atype_t ty[5] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h3};
    int em[5] = '{0, 2, 2, 2, 0};
    av(1'b1, 5'h00, 32'h00100003);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) av(1'b1, 5'h04, 32'hfff04030);
      else if (i == 0) av(1'b1, 5'h04, 32'hfff00030);
      acc(ad[i], ty[i], 1'b0);
      chk("miss edge", em[i], n_miss);
      chk("select cycles", em[i] != 0 ? 0 : 4, n_cs);
    end
  endtask : t_decode

  task automatic t_timing();
    bfcs_word_t ob[6] = '{0, 32'h800, 32'h200, 32'h100, 32'h100, 32'h1};
    logic pv[6] = '{0, 0, 0, 1, 0, 0};
    int ev[6] = '{6, 6, 7, 7, 6, 7};
    int ea[6] = '{6, 7, 7, 7, 6, 8};
    int et[6] = '{1, 1, 1, 1, 1, 1};
    for (int i = 0; i < 6; i++) begin
      av(1'b1, 5'h04, 32'hfff00030 | ob[i]);
      prev_other <= pv[i];
      acc(32'h00100200, 3'h0, 1'b0);
      chk("valid edge", ev[i], v_first);
      chk("ack edge", ea[i], n_ack);
      chk("start cycles", et[i], n_ts);
    end
    prev_other <= 1'b0;
  endtask : t_timing

  task automatic t_sync_burst();
    av(1'b1, 5'h00, 32'h00100001);
    av(1'b1, 5'h04, 32'hfff00020);
    av(1'b1, 5'h08, 32'h00000001);
    for (int i = 0; i < 50; i++) begin
      av(1'b0, 5'h0c, '0);
      if (r[2] === 1'b0 && r[0] === 1'b0) break;
    end
    chk("sync flag", 32'h2, r);
    acc(32'h00100080, 3'h0, 1'b1);
    chk("beats", 4, n_val);
    chk("first beat edge", 5, v_first);
    chk("last beat edge", 8, v_last);
    chk("burst start cycles", 1, n_ts);
    chk("burst strobe cycles", 6, n_bd);
    chk("burst select cycles", 6, n_cs);
    chk("burst ack edge", 8, n_ack);
    av(1'b0, 5'h1c, '0);
    chk("last beat buffer", 32'hff73008c, r);
  endtask : t_sync_burst

  initial begin
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_reset_regs();
    t_boot_read();
    t_decode();
    t_timing();
    t_sync_burst();
    report_and_stop();
  end
endmodule : burst_flash_chip_select_bank_tb
